// ### core/frr_pkg.sv
// package: register codes, field layouts and timing for the fault retry response block
package frr_pkg;
    // command codes of the registers this block touches
    localparam logic [7:0] CMD_OV_WARN_THRESHOLD = 8'h42;
    localparam logic [7:0] CMD_DELAY_UNIT = 8'hD2;
    // fault response byte layout
    localparam int RESP_HI = 7;
    localparam int RESP_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;
    // response modes
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_RUN_DELAY = 2'h1;
    localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
    localparam logic [1:0] RESP_WHILE_PRESENT = 2'h3;
    // retry codes
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_ENDLESS = 3'h7;
    // reset values
    localparam logic [15:0] OV_WARN_RESET = 16'hFFFF;
    localparam logic [15:0] DELAY_UNIT_RESET = 16'h0001;
    // delay unit register counts clock cycles per unit in steps of this many ns
    localparam int UNIT_STEP_NS = 8;
    localparam int CLK_PERIOD_NS = 8;
    localparam logic [15:0] UNIT_STEP_CYC = 16'((UNIT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // sequencer states, gray along run -> delay -> off -> gap
    typedef enum logic [2:0] {
        FRR_RUN = 3'h0,
        FRR_DELAY = 3'h1,
        FRR_OFF = 3'h3,
        FRR_GAP = 3'h2,
        FRR_LATCH = 3'h6,
        FRR_HOLD = 3'h7
    } frr_state_e;
endpackage : frr_pkg

// ### core/frr_timer.sv
// file: delay timer counting 2**n units of a programmable unit length
`timescale 1ns/1ps
`default_nettype none
module frr_timer (
    input wire logic ref_clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic start, // load and start a new delay
    input wire logic [2:0] exp_code, // delay field n
    input wire logic [15:0] unit_len, // unit length in steps
    output logic done // one-cycle pulse at end of delay
);
    logic [15:0] cyc_reg, cyc_next;
    logic [7:0] units_reg, units_next;
    logic run_reg, run_next;
    logic done_next;
    logic [15:0] unit_cyc;

    // a zero unit length would never tick, so clamp it to one step
    assign unit_cyc = (unit_len == 16'h0000) ? frr_pkg::UNIT_STEP_CYC : 16'(unit_len * frr_pkg::UNIT_STEP_CYC);

    // next values of the counters
    always_comb begin
        cyc_next = cyc_reg;
        units_next = units_reg;
        run_next = run_reg;
        done_next = 1'b0;
        if (start) begin
            units_next = 8'(8'h01 << exp_code);
            cyc_next = unit_cyc;
            run_next = 1'b1;
        end else if (run_reg) begin
            if (cyc_reg > 16'h0001) begin
                cyc_next = cyc_reg - 16'h0001;
            end else if (units_reg > 8'h01) begin
                units_next = units_reg - 8'h01;
                cyc_next = unit_cyc;
            end else begin
                run_next = 1'b0;
                done_next = 1'b1;
            end
        end
    end

    // registers only
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cyc_reg <= 16'h0000;
            units_reg <= 8'h00;
            run_reg <= 1'b0;
            done <= 1'b0;
        end else begin
            cyc_reg <= cyc_next;
            units_reg <= units_next;
            run_reg <= run_next;
            done <= done_next;
        end
    end

    // code 0 loads exactly one unit
    unit_load_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        start && exp_code == 3'h0 |=> units_reg == 8'h01)
        else $error("delay code 0 not one unit");
endmodule // frr_timer
`default_nettype wire

// ### core/frr_core.sv
// file: fault response sequencer with retry control and overvoltage warning
`timescale 1ns/1ps
`default_nettype none
module frr_core (
    input wire logic ref_clk, // 125 MHz clock
    input wire logic rstn, // async reset, active low
    input wire logic reg_wr, // register write strobe
    input wire logic [7:0] reg_cmd, // command code of access
    input wire logic [15:0] reg_wdata, // write data
    output logic [15:0] reg_rdata, // read data for reg_cmd
    input wire logic [7:0] fault_resp, // fault response byte
    input wire logic fault_in, // fault condition present
    input wire logic other_fault, // another fault forcing shutdown
    input wire logic out_cmd_on, // output commanded on by pin and operation
    input wire logic bias_ok, // bias power present
    input wire logic clear_faults, // clear latched fault pulse
    input wire logic restart_ok, // restart attempt succeeded
    input wire logic [15:0] vout_meas, // measured output voltage
    output logic out_enable, // power stage enable
    output logic fault_latched, // fault latched, output held off
    output logic [2:0] retries_used, // restart attempts made, held at zero in endless mode
    output logic ov_warn // output above warning threshold
);
    frr_pkg::frr_state_e st_reg, st_next;
    logic [15:0] ov_thr_reg, ov_thr_next;
    logic [15:0] unit_reg, unit_next;
    logic [2:0] tries_reg, tries_next;
    logic out_en_next, latch_next, warn_next;
    logic [15:0] rdata_next;
    logic tmr_start, tmr_done;
    logic [1:0] resp;
    logic [2:0] retry_code;
    logic [2:0] delay_code;
    logic stop_all;

    assign resp = fault_resp[frr_pkg::RESP_HI:frr_pkg::RESP_LO];
    assign retry_code = fault_resp[frr_pkg::RETRY_HI:frr_pkg::RETRY_LO];
    assign delay_code = fault_resp[frr_pkg::DELAY_HI:frr_pkg::DELAY_LO];
    // endless retry ends on off command, bias loss or other fault
    assign stop_all = !out_cmd_on || !bias_ok || other_fault;

    // one timer serves run-on delay and retry gap
    frr_timer u_timer (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .start(tmr_start),
        .exp_code(delay_code),
        .unit_len(unit_reg),
        .done(tmr_done)
    );

    // register file: writes and read mux
    always_comb begin
        ov_thr_next = ov_thr_reg;
        unit_next = unit_reg;
        rdata_next = 16'h0000;
        if (reg_wr && reg_cmd == frr_pkg::CMD_OV_WARN_THRESHOLD) begin
            ov_thr_next = reg_wdata;
        end
        if (reg_wr && reg_cmd == frr_pkg::CMD_DELAY_UNIT) begin
            unit_next = reg_wdata;
        end
        unique case (reg_cmd)
            frr_pkg::CMD_OV_WARN_THRESHOLD: rdata_next = ov_thr_reg;
            frr_pkg::CMD_DELAY_UNIT: rdata_next = unit_reg;
            default: rdata_next = 16'h0000;
        endcase
        // warning only, no effect on output
        warn_next = vout_meas > ov_thr_reg;
    end

    // sequencer next state
    always_comb begin
        st_next = st_reg;
        tries_next = tries_reg;
        tmr_start = 1'b0;
        out_en_next = out_enable;
        latch_next = fault_latched;
        unique case (st_reg)
            frr_pkg::FRR_RUN: begin
                out_en_next = out_cmd_on && bias_ok;
                tries_next = 3'h0;
                if (fault_in) begin
                    unique case (resp)
                        frr_pkg::RESP_IGNORE: st_next = frr_pkg::FRR_RUN;
                        frr_pkg::RESP_RUN_DELAY: begin
                            tmr_start = 1'b1;
                            st_next = frr_pkg::FRR_DELAY;
                        end
                        frr_pkg::RESP_SHUTDOWN: begin
                            out_en_next = 1'b0;
                            st_next = frr_pkg::FRR_OFF;
                        end
                        frr_pkg::RESP_WHILE_PRESENT: begin
                            out_en_next = 1'b0;
                            st_next = frr_pkg::FRR_HOLD;
                        end
                    endcase
                end
            end
            frr_pkg::FRR_DELAY: begin
                if (!fault_in) begin
                    st_next = frr_pkg::FRR_RUN;
                end else if (tmr_done) begin
                    out_en_next = 1'b0;
                    st_next = frr_pkg::FRR_OFF;
                end
            end
            frr_pkg::FRR_OFF: begin
                // ends the one-cycle restart pulse of a failed attempt
                out_en_next = 1'b0;
                if (retry_code == frr_pkg::RETRY_NONE || stop_all) begin
                    latch_next = 1'b1;
                    st_next = frr_pkg::FRR_LATCH;
                end else if (retry_code != frr_pkg::RETRY_ENDLESS && tries_reg >= retry_code) begin
                    latch_next = 1'b1;
                    st_next = frr_pkg::FRR_LATCH;
                end else begin
                    tmr_start = 1'b1;
                    st_next = frr_pkg::FRR_GAP;
                end
            end
            frr_pkg::FRR_GAP: begin
                if (stop_all) begin
                    latch_next = 1'b1;
                    st_next = frr_pkg::FRR_LATCH;
                end else if (tmr_done) begin
                    // restart attempt begins here
                    out_en_next = 1'b1;
                    if (retry_code != frr_pkg::RETRY_ENDLESS) begin
                        tries_next = tries_reg + 3'h1;
                    end
                    if (restart_ok && !fault_in) begin
                        st_next = frr_pkg::FRR_RUN;
                    end else begin
                        // failed attempt keeps the stage on for one cycle, else no attempt is really made
                        st_next = frr_pkg::FRR_OFF;
                    end
                end
            end
            frr_pkg::FRR_LATCH: begin
                // held off until the fault is cleared or bias is lost
                out_en_next = 1'b0;
                if (clear_faults || !bias_ok) begin
                    latch_next = 1'b0;
                    st_next = frr_pkg::FRR_RUN;
                end
            end
            frr_pkg::FRR_HOLD: begin
                out_en_next = 1'b0;
                if (!fault_in) begin
                    st_next = frr_pkg::FRR_RUN;
                end
            end
            default: begin
                out_en_next = 1'b0;
                st_next = frr_pkg::FRR_RUN;
            end
        endcase
    end

    // all registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= frr_pkg::FRR_RUN;
            tries_reg <= 3'h0;
            out_enable <= 1'b0;
            fault_latched <= 1'b0;
            ov_thr_reg <= frr_pkg::OV_WARN_RESET;
            unit_reg <= frr_pkg::DELAY_UNIT_RESET;
            reg_rdata <= 16'h0000;
            ov_warn <= 1'b0;
        end else begin
            st_reg <= st_next;
            tries_reg <= tries_next;
            out_enable <= out_en_next;
            fault_latched <= latch_next;
            ov_thr_reg <= ov_thr_next;
            unit_reg <= unit_next;
            reg_rdata <= rdata_next;
            ov_warn <= warn_next;
        end
    end
    assign retries_used = tries_reg;

    // never more attempts than the finite code allows
    retry_bound_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        retry_code != frr_pkg::RETRY_ENDLESS && st_reg != frr_pkg::FRR_RUN |-> tries_reg <= retry_code)
        else $error("too many retries");
    // latched state keeps output off
    latch_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        st_reg == frr_pkg::FRR_LATCH |=> !out_enable)
        else $error("output on while latched");
    // gap start reloads the timer, so a stale done pulse cannot cut the gap short
    gap_start_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        st_reg == frr_pkg::FRR_OFF && st_next == frr_pkg::FRR_GAP |=> st_reg == frr_pkg::FRR_GAP && !tmr_done)
        else $error("gap without timer");
    // endless mode stops on loss of bias
    endless_stop_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        st_reg == frr_pkg::FRR_GAP && !bias_ok |=> st_reg == frr_pkg::FRR_LATCH)
        else $error("retry not stopped");
    // zero retry code goes straight to latch
    no_retry_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        st_reg == frr_pkg::FRR_OFF && retry_code == frr_pkg::RETRY_NONE |=> fault_latched)
        else $error("retried on code 000");
    // shutdown response drops output next cycle
    shutdown_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        st_reg == frr_pkg::FRR_RUN && fault_in && resp == frr_pkg::RESP_SHUTDOWN |=> !out_enable)
        else $error("no shutdown");
    // threshold write lands
    thr_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        reg_wr && reg_cmd == frr_pkg::CMD_OV_WARN_THRESHOLD |=> ov_thr_reg == $past(reg_wdata))
        else $error("threshold lost");
    // warning follows compare
    warn_flag_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        vout_meas > ov_thr_reg |=> ov_warn)
        else $error("warning missed");
endmodule // frr_core
`default_nettype wire

// ### testbench/frr_host.sv
// host model: register writes and reads on the command port
`timescale 1ns/1ps
`default_nettype none
module frr_host (
    input wire logic ref_clk, // system clock
    output logic reg_wr, // write strobe
    output logic [7:0] reg_cmd, // command code
    output logic [15:0] reg_wdata, // write data
    input wire logic [15:0] reg_rdata // read data
);
    // idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_cmd = 8'h00;
        reg_wdata = 16'h0000;
    end
    // strobe spans exactly one rising edge
    task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
        @(negedge ref_clk);
        reg_cmd = cmd;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_wdata = ~data; // stale data must never look valid
    endtask
    // read data is registered, so two rising edges pass before sampling
    task automatic rd(input logic [7:0] cmd, output logic [15:0] data);
        @(negedge ref_clk);
        reg_cmd = cmd;
        repeat (2) @(negedge ref_clk);
        data = reg_rdata;
    endtask
endmodule // frr_host
`default_nettype wire

// ### testbench/frr_core_tb.sv
// testbench for the fault retry response sequencer
`timescale 1ns/1ps
`default_nettype none
module frr_core_tb;
    localparam int UNIT = 2;
    localparam int LIMIT = 40000;
    logic ref_clk, rstn, reg_wr, fault_in, other_fault, out_cmd_on, bias_ok, clear_faults, restart_ok;
    logic out_enable, fault_latched, ov_warn;
    logic [7:0] reg_cmd, fault_resp;
    logic [15:0] reg_wdata, reg_rdata, vout_meas, d;
    logic [2:0] retries_used;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int n, g[3], r[2];
    frr_core i_frr_core (.ref_clk(ref_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_cmd(reg_cmd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fault_resp(fault_resp), .fault_in(fault_in),
        .other_fault(other_fault), .out_cmd_on(out_cmd_on), .bias_ok(bias_ok), .clear_faults(clear_faults),
        .restart_ok(restart_ok), .vout_meas(vout_meas), .out_enable(out_enable),
        .fault_latched(fault_latched), .retries_used(retries_used), .ov_warn(ov_warn));
    frr_host i_frr_host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_cmd(reg_cmd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));
    // 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // hang guard: a stuck wait still reaches the verdict
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge ref_clk);
    endtask
    // bounded wait for a level on the output enable
    task automatic wait_en(input logic v, output int k);
        k = 0;
        while (out_enable !== v && k < 1000) begin
            @(negedge ref_clk);
            k++;
        end
    endtask
    // restart pulses seen; stops early once a fault is latched
    task automatic pulses(input int k, output int p);
        logic prev;
        p = 0;
        prev = out_enable;
        repeat (k) begin
            @(negedge ref_clk);
            if (out_enable === 1'b1 && prev !== 1'b1) p++;
            prev = out_enable;
            if (fault_latched === 1'b1) break;
        end
    endtask
    // cycles in which the output was not on
    task automatic held(input int k, output int p);
        p = 0;
        repeat (k) begin
            @(negedge ref_clk);
            if (out_enable !== 1'b1) p++;
        end
    endtask
    // back to normal operation through a clear pulse
    task automatic recover();
        fault_in = 1'b0;
        restart_ok = 1'b0;
        other_fault = 1'b0;
        out_cmd_on = 1'b1;
        bias_ok = 1'b1;
        // a shutdown still under way must reach the latch before the clear, or the clear is lost
        tick(4);
        clear_faults = 1'b1;
        tick(1);
        clear_faults = 1'b0;
        tick(4);
        check(out_enable, 1);
        check(fault_latched, 0);
    endtask
    task automatic t_regs();
        i_frr_host.rd(8'h42, d);
        check(d, frr_pkg::OV_WARN_RESET);
        i_frr_host.rd(8'hD2, d);
        check(d, frr_pkg::DELAY_UNIT_RESET);
        i_frr_host.wr(8'h42, 16'h1234);
        i_frr_host.wr(8'hD2, 16'(UNIT));
        i_frr_host.wr(8'h43, 16'hBEEF); // unmapped code is ignored
        i_frr_host.rd(8'h42, d);
        check(d, 16'h1234);
        i_frr_host.rd(8'hD2, d);
        check(d, 16'(UNIT));
        i_frr_host.rd(8'h43, d);
        check(d, 16'h0000);
    endtask
    task automatic t_warn();
        vout_meas = 16'h1234; // equal is not above
        tick(3);
        check(ov_warn, 0);
        vout_meas = 16'h1235;
        tick(3);
        check(ov_warn, 1);
        check(out_enable, 1);
        vout_meas = 16'h0000;
        tick(3);
        check(ov_warn, 0);
    endtask
    // finite attempt counts, then latched off
    task automatic t_retry();
        for (int c = 0; c < 7; c++) begin
            fault_resp = {2'h2, 3'(c), 3'h0};
            fault_in = 1'b1;
            pulses(2000, n);
            check(n, c);
            check(retries_used, c);
            tick(20);
            check(out_enable, 0);
            check(fault_latched, 1);
            recover();
        end
    endtask
    // spacing grows by 2**n units; overhead cancels in the difference
    task automatic t_gap();
        for (int i = 0; i < 3; i++) begin
            fault_resp = {2'h2, 3'h2, (i == 0) ? 3'h0 : (i == 1) ? 3'h3 : 3'h7};
            fault_in = 1'b1;
            wait_en(0, n);
            wait_en(1, n);
            wait_en(0, n);
            wait_en(1, g[i]);
            recover();
        end
        check(g[1] - g[0], 7 * UNIT);
        check(g[2] - g[0], 127 * UNIT);
    endtask
    // run-on time and the run-on, ignore and while-present response modes
    task automatic t_modes();
        for (int i = 0; i < 2; i++) begin
            fault_resp = {2'h1, 3'h0, (i == 0) ? 3'h0 : 3'h4};
            fault_in = 1'b1;
            wait_en(0, r[i]);
            recover();
        end
        check(r[1] - r[0], 15 * UNIT);
        fault_resp = {2'h1, 3'h0, 3'h7};
        fault_in = 1'b1;
        held(20, n);
        check(n, 0);
        fault_in = 1'b0;
        held(300, n);
        check(n, 0);
        fault_resp = {2'h0, 3'h6, 3'h0};
        fault_in = 1'b1;
        held(50, n);
        check(n, 0);
        fault_resp = {2'h3, 3'h0, 3'h0};
        tick(5);
        check(out_enable, 0);
        fault_in = 1'b0;
        tick(5);
        check(out_enable, 1);
        check(fault_latched, 0);
    endtask
    // endless retries end on each stop cause or on success
    task automatic t_endless();
        for (int k = 0; k < 4; k++) begin
            fault_resp = {2'h2, 3'h7, 3'h0};
            fault_in = 1'b1;
            pulses(400, n);
            check(n > 8, 1);
            check(retries_used, 0);
            out_cmd_on = (k != 0);
            bias_ok = (k != 1);
            other_fault = (k == 2);
            if (k == 3) begin
                fault_in = 1'b0;
                restart_ok = 1'b1;
                tick(40);
                held(30, n);
            end else pulses(300, n);
            check(n, 0);
            recover();
        end
    endtask
    initial begin
        rstn = 1'b0;
        fault_resp = 8'h00;
        fault_in = 1'b0;
        other_fault = 1'b0;
        out_cmd_on = 1'b1;
        bias_ok = 1'b1;
        clear_faults = 1'b0;
        restart_ok = 1'b0;
        vout_meas = 16'h0000;
        tick(3);
        rstn = 1'b1;
        t_regs();
        t_warn();
        t_retry();
        t_gap();
        t_modes();
        t_endless();
        wrap_up();
    end
endmodule // frr_core_tb
`default_nettype wire
